// file: design/uep_pkg.sv
// package for the endpoint-zero control/status block
// assumes a single 10 MHz clock and an 8-bit register port
package uep_pkg;

  // register map
  localparam logic [7:0] UEP_ADDR_EP0_CSR = 8'h11;
  localparam logic [7:0] UEP_ADDR_RX_COUNT = 8'h16;
  localparam logic [7:0] UEP_ADDR_INT_STATUS = 8'h20;
  localparam logic [7:0] UEP_ADDR_INT_MASK = 8'h21;
  localparam logic [7:0] UEP_CSR_RESET = 8'h00;

  // control/status bit positions
  localparam int UEP_BIT_SRV_SETUP_END = 7;
  localparam int UEP_BIT_SRV_OUT_READY = 6;
  localparam int UEP_BIT_SEND_STALL = 5;
  localparam int UEP_BIT_SETUP_END = 4;
  localparam int UEP_BIT_DATA_END = 3;
  localparam int UEP_BIT_STALL_SENT = 2;
  localparam int UEP_BIT_IN_READY = 1;
  localparam int UEP_BIT_OUT_READY = 0;

  // interrupt status bit positions
  localparam int UEP_IRQ_RX_PACKET = 0;
  localparam int UEP_IRQ_IN_CLEARED = 1;
  localparam int UEP_IRQ_STALL = 2;
  localparam int UEP_IRQ_SETUP_END = 3;
  localparam int UEP_IRQ_WIDTH = 4;

  localparam int UEP_COUNT_WIDTH = 7;

  // events reported by the serial interface engine, one-cycle pulses
  typedef struct packed {
    logic rx_packet_done;
    logic [UEP_COUNT_WIDTH-1:0] rx_byte_count;
    logic in_packet_sent;
    logic setup_overwrite;
    logic out_overwrite;
    logic stall_sent;
    logic xfer_end;
    logic in_token;
  } uep_sie_event_t;

  // answers to the serial interface engine
  typedef struct packed {
    logic in_ready;
    logic stall_req;
    logic data_end;
    logic nak_in;
  } uep_sie_ctrl_t;

endpackage

// file: design/uep_ctrl.sv
// endpoint-zero control/status register with event-driven flags
// assumes engine events are single-cycle pulses on clock_in
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module uep_ctrl
  import uep_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic srst_in,
  // register port
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  // serial interface engine
  input wire uep_sie_event_t sie_event_in,
  output uep_sie_ctrl_t sie_ctrl_out,
  // interrupt
  output logic irq_out
);

  ////////////////////////////////////////////////////////////////////////////
  logic send_stall_request_reg;
  logic setup_end_flag_reg;
  logic data_end_marker_reg;
  logic stall_sent_flag_reg;
  logic in_packet_ready_reg;
  logic out_packet_ready_reg;
  logic [UEP_COUNT_WIDTH-1:0] rx_count_reg;
  logic [UEP_IRQ_WIDTH-1:0] irq_status_reg;
  logic [UEP_IRQ_WIDTH-1:0] irq_mask_reg;
  logic csr_wr;
  logic status_wr;
  logic in_cleared;
  logic [UEP_IRQ_WIDTH-1:0] irq_set;

  assign csr_wr = wr_in && (addr_in == UEP_ADDR_EP0_CSR);
  assign status_wr = wr_in && (addr_in == UEP_ADDR_INT_STATUS);
  assign in_cleared = in_packet_ready_reg &&
    (sie_event_in.in_packet_sent || sie_event_in.setup_overwrite || sie_event_in.out_overwrite);

  ////////////////////////////////////////////////////////////////////////////
  // setup-end: a set in the same cycle as the serviced strobe wins
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      setup_end_flag_reg <= UEP_CSR_RESET[UEP_BIT_SETUP_END];
    end else if (sie_event_in.xfer_end && !data_end_marker_reg) begin
      setup_end_flag_reg <= 1'b1;
    end else if (csr_wr && wdata_in[UEP_BIT_SRV_SETUP_END]) begin
      setup_end_flag_reg <= 1'b0;
    end
  end

  // out-ready: only the serviced strobe clears it
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      out_packet_ready_reg <= UEP_CSR_RESET[UEP_BIT_OUT_READY];
    end else if (sie_event_in.rx_packet_done) begin
      out_packet_ready_reg <= 1'b1;
    end else if (csr_wr && wdata_in[UEP_BIT_SRV_OUT_READY]) begin
      out_packet_ready_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      rx_count_reg <= '0;
    end else if (sie_event_in.rx_packet_done) begin
      rx_count_reg <= sie_event_in.rx_byte_count;
    end
  end

  // send-stall: software can only set it, the engine clears it
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      send_stall_request_reg <= UEP_CSR_RESET[UEP_BIT_SEND_STALL];
    end else if (csr_wr && wdata_in[UEP_BIT_SEND_STALL]) begin
      send_stall_request_reg <= 1'b1;
    end else if (sie_event_in.stall_sent) begin
      send_stall_request_reg <= 1'b0;
    end
  end

  // stall-sent: hardware sets, software writes zero to clear
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      stall_sent_flag_reg <= UEP_CSR_RESET[UEP_BIT_STALL_SENT];
    end else if (sie_event_in.stall_sent) begin
      stall_sent_flag_reg <= 1'b1;
    end else if (csr_wr && !wdata_in[UEP_BIT_STALL_SENT]) begin
      stall_sent_flag_reg <= 1'b0;
    end
  end

  // data-end: held until the transfer ends or a stall is sent, then dropped by hardware
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      data_end_marker_reg <= UEP_CSR_RESET[UEP_BIT_DATA_END];
    end else if (csr_wr && wdata_in[UEP_BIT_DATA_END]) begin
      data_end_marker_reg <= 1'b1;
    end else if (sie_event_in.xfer_end || sie_event_in.stall_sent) begin
      data_end_marker_reg <= 1'b0;
    end
  end

  // in-ready: engine clearing beats a same-cycle software set
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      in_packet_ready_reg <= UEP_CSR_RESET[UEP_BIT_IN_READY];
    end else if (in_cleared) begin
      in_packet_ready_reg <= 1'b0;
    end else if (csr_wr && wdata_in[UEP_BIT_IN_READY]) begin
      in_packet_ready_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts: write one to clear, new events win
  always_comb begin
    irq_set = '0;
    irq_set[UEP_IRQ_RX_PACKET] = sie_event_in.rx_packet_done;
    irq_set[UEP_IRQ_IN_CLEARED] = in_cleared;
    irq_set[UEP_IRQ_STALL] = sie_event_in.stall_sent;
    irq_set[UEP_IRQ_SETUP_END] = sie_event_in.xfer_end && !data_end_marker_reg;
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      irq_status_reg <= '0;
    end else if (status_wr) begin
      irq_status_reg <= (irq_status_reg & ~wdata_in[UEP_IRQ_WIDTH-1:0]) | irq_set;
    end else begin
      irq_status_reg <= irq_status_reg | irq_set;
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      irq_mask_reg <= '0;
    end else if (wr_in && addr_in == UEP_ADDR_INT_MASK) begin
      irq_mask_reg <= wdata_in[UEP_IRQ_WIDTH-1:0];
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |((irq_status_reg | irq_set) & irq_mask_reg &
        ~(status_wr ? wdata_in[UEP_IRQ_WIDTH-1:0] & ~irq_set : '0));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // engine controls
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      sie_ctrl_out <= '0;
    end else begin
      sie_ctrl_out.in_ready <= in_packet_ready_reg;
      sie_ctrl_out.stall_req <= send_stall_request_reg;
      sie_ctrl_out.data_end <= data_end_marker_reg;
      sie_ctrl_out.nak_in <= sie_event_in.in_token && !in_packet_ready_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      rdata_out <= '0;
    end else if (rd_in) begin
      unique case (addr_in)
        UEP_ADDR_EP0_CSR: begin
          // serviced strobes always read zero
          rdata_out <= {1'b0, 1'b0, send_stall_request_reg, setup_end_flag_reg,
            data_end_marker_reg, stall_sent_flag_reg, in_packet_ready_reg, out_packet_ready_reg};
        end
        UEP_ADDR_RX_COUNT: begin
          rdata_out <= {1'b0, rx_count_reg};
        end
        UEP_ADDR_INT_STATUS: begin
          rdata_out <= {{(8-UEP_IRQ_WIDTH){1'b0}}, irq_status_reg};
        end
        UEP_ADDR_INT_MASK: begin
          rdata_out <= {{(8-UEP_IRQ_WIDTH){1'b0}}, irq_mask_reg};
        end
        default: begin
          rdata_out <= '0;
        end
      endcase
    end else begin
      rdata_out <= '0;
    end
  end

endmodule
`default_nettype wire

// file: sim/uep_ctrl_assertions.sv
// checker for the endpoint-zero control block
// sees only the top ports; bound from the bench top file
`timescale 1ns/100ps
`default_nettype none
module uep_ctrl_chk
  import uep_pkg::*;
(
  // watched ports
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  input wire uep_sie_event_t sie_event_in,
  input wire uep_sie_ctrl_t sie_ctrl_out,
  input wire logic irq_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (srst_in);
  logic csr_wr;
  assign csr_wr = wr_in && addr_in == UEP_ADDR_EP0_CSR;
  a_strobe_read_zero: assert property (rd_in && addr_in == UEP_ADDR_EP0_CSR |=> rdata_out[7:6] == 2'h0)
    else $error("serviced strobe bits read back as one");
  a_idle_read_zero: assert property (!rd_in |=> rdata_out == 8'h00)
    else $error("read data outside its read cycle");
  a_stall_req_set: assert property (
    csr_wr && wdata_in[5] && !sie_event_in.stall_sent ##1 !sie_event_in.stall_sent |=> sie_ctrl_out.stall_req)
    else $error("stall request not raised");
  a_stall_req_clear: assert property (
    sie_event_in.stall_sent && !(csr_wr && wdata_in[5]) ##1 !(csr_wr && wdata_in[5]) |=> !sie_ctrl_out.stall_req)
    else $error("stall request kept after stall sent");
  a_nak_when_empty: assert property (sie_event_in.in_token |=> sie_ctrl_out.nak_in == !sie_ctrl_out.in_ready)
    else $error("nak answer does not match in-ready");
  a_nak_cause: assert property (sie_ctrl_out.nak_in |-> $past(sie_event_in.in_token))
    else $error("nak without an in token");
  a_in_ready_clear: assert property (
    (sie_event_in.in_packet_sent || sie_event_in.setup_overwrite || sie_event_in.out_overwrite) &&
    !(csr_wr && wdata_in[1]) ##1 !(csr_wr && wdata_in[1]) |=> !sie_ctrl_out.in_ready)
    else $error("in-ready kept after send or overwrite");
  a_data_end_clear: assert property (
    (sie_event_in.xfer_end && !csr_wr) ##1 !csr_wr |=> !sie_ctrl_out.data_end)
    else $error("data end kept after transfer end");
endmodule
`default_nettype wire

// file: sim/uep_sie_model.sv
// engine stand-in: turns one-cycle bench requests into event pulses
// count is garbage except beside rx_packet_done
`timescale 1ns/100ps
`default_nettype none
module uep_sie_model
  import uep_pkg::*;
(
  // clock
  input wire logic clock_in,
  // requests, bit 6 down to 0 in event struct order
  input wire logic [6:0] req_in,
  input wire logic [6:0] count_in,
  // to the block
  output var uep_sie_event_t event_out
);
  logic [6:0] last_reg;
  initial event_out = '0;
  initial last_reg = '0;
  always @(posedge clock_in) begin
    // count pairs with the packet pulse only; otherwise inverted junk
    event_out <= {req_in[6], req_in[6] ? count_in : ~last_reg, req_in[5:0]};
    last_reg <= req_in[6] ? count_in : ~last_reg;
  end
endmodule
`default_nettype wire

// file: sim/tb_uep_ctrl.sv
// self-checking bench for the endpoint-zero control block
// drives the register port directly and the engine side through the model
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_mismatch++; $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module tb_uep_ctrl
  import uep_pkg::*;
;
  logic clock_in = 1'b0;
  logic srst_in = 1'b1;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [7:0] wdata_in = 8'h00;
  logic [7:0] rdata_out;
  logic [7:0] m;
  logic [6:0] req = 7'h00;
  logic [6:0] cnt = 7'h00;
  logic irq_out;
  uep_sie_event_t sie_event;
  uep_sie_ctrl_t sie_ctrl;
  int n_mismatch = 0;
  int tests_run = 0;
  int cycles = 0;
  uep_ctrl uep_ctrl_i (.clock_in(clock_in), .srst_in(srst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .sie_event_in(sie_event), .sie_ctrl_out(sie_ctrl),
    .irq_out(irq_out));
  uep_sie_model uep_sie_model_i (.clock_in(clock_in), .req_in(req), .count_in(cnt), .event_out(sie_event));
  initial forever #50 clock_in = ~clock_in;
  always @(posedge clock_in) if (++cycles == 5000) begin
    n_mismatch++;
    close_out();
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock_in);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge clock_in);
    wr_in <= 1'b0;
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clock_in);
    rd_in <= 1'b0;
    @(negedge clock_in);
    `CHK(rdata_out, e)
  endtask
  task automatic ev(input logic [6:0] r, input logic [6:0] c);
    @(posedge clock_in);
    req <= r;
    cnt <= c;
    @(posedge clock_in);
    req <= 7'h00;
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(32'h8805bcfa));
    repeat (4) @(posedge clock_in);
    srst_in <= 1'b0;
    chk_rd(UEP_ADDR_EP0_CSR, UEP_CSR_RESET);
    chk_rd(UEP_ADDR_RX_COUNT, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      m = (i == 0) ? 8'hff : 8'($urandom);
      wr(UEP_ADDR_INT_MASK, {7'h00, m[7]});
      ev(7'h40, m[6:0]);
      chk_rd(UEP_ADDR_EP0_CSR, 8'h01);
      `CHK(irq_out, m[7])
      chk_rd(UEP_ADDR_RX_COUNT, {1'b0, m[6:0]});
      wr(UEP_ADDR_EP0_CSR, 8'h00);
      chk_rd(UEP_ADDR_EP0_CSR, 8'h01);
      wr(UEP_ADDR_EP0_CSR, 8'h40);
      chk_rd(UEP_ADDR_EP0_CSR, 8'h00);
      chk_rd(UEP_ADDR_INT_STATUS, 8'h01);
      wr(UEP_ADDR_INT_STATUS, 8'h01);
    end
    $display("test out packet done");
    wr(UEP_ADDR_INT_MASK, 8'h0f);
    for (int k = 0; k < 3; k++) begin
      wr(UEP_ADDR_EP0_CSR, 8'h02);
      ev(7'h01, 7'h00);
      chk_rd(UEP_ADDR_EP0_CSR, 8'h02);
      ev(7'h20 >> k, 7'h00);
      chk_rd(UEP_ADDR_EP0_CSR, 8'h00);
      `CHK(irq_out, 1'b1)
      ev(7'h01, 7'h00);
      chk_rd(UEP_ADDR_INT_STATUS, 8'h02);
      wr(UEP_ADDR_INT_STATUS, 8'h02);
    end
    $display("test in packet done");
    wr(UEP_ADDR_EP0_CSR, 8'h20);
    chk_rd(UEP_ADDR_EP0_CSR, 8'h20);
    ev(7'h04, 7'h00);
    chk_rd(UEP_ADDR_EP0_CSR, 8'h04);
    wr(UEP_ADDR_EP0_CSR, 8'h04);
    chk_rd(UEP_ADDR_EP0_CSR, 8'h04);
    wr(UEP_ADDR_EP0_CSR, 8'h00);
    chk_rd(UEP_ADDR_EP0_CSR, 8'h00);
    $display("test stall done");
    ev(7'h02, 7'h00);
    chk_rd(UEP_ADDR_EP0_CSR, 8'h10);
    wr(UEP_ADDR_EP0_CSR, 8'h00);
    chk_rd(UEP_ADDR_EP0_CSR, 8'h10);
    wr(UEP_ADDR_EP0_CSR, 8'h80);
    chk_rd(UEP_ADDR_EP0_CSR, 8'h00);
    wr(UEP_ADDR_EP0_CSR, 8'h08);
    ev(7'h02, 7'h00);
    chk_rd(UEP_ADDR_EP0_CSR, 8'h00);
    wr(8'h3c, 8'hff);
    chk_rd(8'h3c, 8'h00);
    wr(UEP_ADDR_INT_STATUS, 8'h0f);
    // irq_out is launched by the same edge that took the write; look once it has settled
    @(negedge clock_in);
    `CHK(irq_out, 1'b0)
    $display("test setup end done");
    close_out();
  end
endmodule
bind uep_ctrl uep_ctrl_chk uep_ctrl_chk_i (.clock_in, .srst_in, .addr_in, .wdata_in, .wr_in, .rd_in,
  .rdata_out, .sie_event_in, .sie_ctrl_out, .irq_out);
`default_nettype wire
